// ---- logic/atr_pkg.sv ----
// Package for the task-file and buffer configuration register bank.
// Assumes one clock (mclk) shared by the sub-CPU register port and the
// host task-file port, both already decoded into strobes on that clock.
package atr_pkg;

  // ----------
  // Sub-CPU write register numbers
  // ----------
  localparam logic [4:0] ATR_W_BUFFER_MEMORY_CONFIG = 5'h14;
  localparam logic [4:0] ATR_W_STATUS = 5'h15;
  localparam logic [4:0] ATR_W_TRIGGER = 5'h16;
  localparam logic [4:0] ATR_W_DRVADDR = 5'h17;
  localparam logic [4:0] ATR_W_SECTOR = 5'h18;
  localparam logic [4:0] ATR_W_XFER = 5'h19;
  localparam logic [4:0] ATR_W_DRVHEAD = 5'h1a;
  localparam logic [4:0] ATR_W_REASON = 5'h1b;
  localparam logic [4:0] ATR_W_ERROR = 5'h1c;
  localparam logic [4:0] ATR_W_RESET = 5'h1f;

  // ----------
  // Sub-CPU read register numbers
  // ----------
  localparam logic [4:0] ATR_R_COMMAND = 5'h11;
  localparam logic [4:0] ATR_R_SECTOR = 5'h12;
  localparam logic [4:0] ATR_R_DEVCTL = 5'h13;
  localparam logic [4:0] ATR_R_DRVHEAD = 5'h14;
  localparam logic [4:0] ATR_R_REASON = 5'h15;
  localparam logic [4:0] ATR_R_FEATURES = 5'h16;
  localparam logic [4:0] ATR_R_BUFFER_MEMORY_CONFIG = 5'h1d;
  localparam logic [4:0] ATR_R_XFER = 5'h1e;

  // ----------
  // Host task-file register numbers
  // ----------
  localparam logic [3:0] ATR_H_ERRFEAT = 4'h1;
  localparam logic [3:0] ATR_H_REASON = 4'h2;
  localparam logic [3:0] ATR_H_SECTOR = 4'h3;
  localparam logic [3:0] ATR_H_DRVHEAD = 4'h6;
  localparam logic [3:0] ATR_H_STATCMD = 4'h7;
  localparam logic [3:0] ATR_H_DEVCTL = 4'he;
  localparam logic [3:0] ATR_H_DRVADDR = 4'hf;

  // ----------
  // Field positions and reset values
  // ----------
  localparam int ATR_PRIO_HI = 6;
  localparam int ATR_PRIO_LO = 5;
  localparam int ATR_REFRESH_DIVISOR_SEL_BIT = 3;
  localparam int ATR_WIDTH_BIT = 2;
  localparam int ATR_STATIC_BIT = 1;
  localparam int ATR_CACHE_BIT = 0;
  localparam int ATR_BSY_BIT = 7;
  localparam int ATR_DRV_BIT = 4;
  localparam int ATR_SRST_BIT = 2;
  localparam int ATR_MULTI_BIT = 6;
  localparam int ATR_USE_DMA_SEL_BIT = 5;
  localparam int ATR_SUBCODE_IRQ_ENABLE_BIT = 4;
  localparam int ATR_REAL_DRIVE_NUMBER_BIT = 3;
  localparam logic [7:0] ATR_STATUS_RST = 8'h80;
  localparam logic [7:0] ATR_XFER_RST = 8'h08;
  localparam logic [7:0] ATR_BUFFER_MEMORY_CONFIG_RST = 8'h00;
  localparam logic [7:0] ATR_DRVHEAD_ONES = 8'he0;
  localparam logic [7:0] ATR_CMD_DIAG = 8'h90;

  // ----------
  // Host modes and transfer types
  // ----------
  localparam logic [2:0] ATR_HSEL_LEGACY_A = 3'h0;
  localparam logic [2:0] ATR_HSEL_ATAPI = 3'h1;
  localparam logic [2:0] ATR_HSEL_LEGACY_B = 3'h2;
  localparam logic [2:0] ATR_HSEL_RST = 3'h7;
  localparam logic [2:0] ATR_TT_HOST_TO_SUB = 3'h4;
  localparam logic [2:0] ATR_TT_SUB_TO_HOST = 3'h5;
  localparam logic [15:0] ATR_MAX_ATAPI = 16'hffff;
  localparam logic [15:0] ATR_MAX_LEGACY = 16'h7fff;
  localparam logic [15:0] ATR_MAX_PACKET = 16'h000c;

  // ----------
  // Refresh divisors
  // ----------
  localparam int ATR_RFR_DIV_SLOW = 400;
  localparam int ATR_RFR_DIV_FAST = 200;
  localparam logic [8:0] ATR_RFR_TOP_SLOW = 9'(ATR_RFR_DIV_SLOW - 1);
  localparam logic [8:0] ATR_RFR_TOP_FAST = 9'(ATR_RFR_DIV_FAST - 1);

  // Buffer memory configuration as seen by the memory controller
  typedef struct packed {
    logic [2:0] host_burst;
    logic nibble_wide;
    logic sram_sel;
    logic no_cache;
  } atr_mem_cfg_t;

  // Transfer setup as seen by the transfer datapath
  typedef struct packed {
    logic [2:0] transfer_type;
    logic use_dma_sel;
    logic multiword_sel;
    logic subcode_irq_enable;
    logic use_byte_counter;
    logic [15:0] max_bytes;
  } atr_xfer_cfg_t;

endpackage : atr_pkg

// ---- logic/atr_regs.sv ----
// Register bank holding buffer memory setup, the packet task file and
// the transfer control register, seen from the sub-CPU and the host.
// Assumes the serial sub-CPU port and the host bus decoder deliver
// one-cycle strobes synchronous to mclk; no pin is sampled here.
//
// Function
// - Priority field gives one to four host accesses
// - DRAM refresh request every 400 or 200 clocks
// - Width bit selects nibble or byte DRAM
// - Type bit selects SRAM or DRAM buffer
// - Cache bit set means no internal cache
// - Trigger write raises host irq; status/command clear
// - Legacy modes ignore trigger writes
// - Status register write-only, packet mode, bit7 busy
// - Busy set by command, diagnostic, SRST, reset
// - Status register resets to 80h
// - Command write raises command irq and busy
// - Reading command register clears command irq
// - Reading device control clears soft-reset irq
// - Drive/head top bits ones; drive-select gates response
// - Transfer control resets zero, real drive one
// - Bit6 multiword, bit5 DMA versus PIO
// - Bit4 subcode irq enable, bit3 drive number
// - Transfer type paths and byte limits
// - Packet types twelve bytes, host-to-sub PIO only
// - Task file access directions from sub-CPU
// - Reset register host-select field picks host mode
`timescale 1ns/1ps

module atr_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Sub-CPU register port
  input wire logic [4:0] sub_addr,
  input wire logic sub_wr,
  input wire logic sub_rd,
  input wire logic [7:0] sub_wdata,
  output logic [7:0] sub_rdata,
  // Host task-file port
  input wire logic [3:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Interrupt levels
  output logic host_irq,
  output logic command_received_irq,
  output logic soft_reset_irq,
  // Host mode
  output logic [2:0] host_mode,
  output logic host_pins_tristate,
  output logic atapi_mode,
  // Buffer memory controller
  output atr_pkg::atr_mem_cfg_t mem_cfg,
  output logic refresh_req,
  // Transfer datapath
  output atr_pkg::atr_xfer_cfg_t xfer_cfg,
  output logic busy
);
  import atr_pkg::*;

  // ----------
  // Register state
  // ----------
  logic [7:0] buffer_memory_config_q;
  logic [7:0] status_q;
  logic [7:0] command_q;
  logic [7:0] drvaddr_q;
  logic [7:0] sector_q;
  logic [7:0] devctl_q;
  logic [7:0] drvhead_q;
  logic [7:0] reason_q;
  logic [7:0] features_q;
  logic [7:0] error_q;
  logic [7:0] xfer_q;
  logic [2:0] hsel_q;
  logic atapi_q;
  logic pins_off_q;
  logic host_irq_q;
  logic cmd_irq_q;
  logic srst_irq_q;
  logic [8:0] rfr_cnt_q;
  logic refresh_q;
  logic [7:0] sub_rdata_q;
  logic [7:0] host_rdata_q;
  atr_mem_cfg_t mem_cfg_q;
  atr_xfer_cfg_t xfer_cfg_q;

  // Sub-CPU read and write decode
  function automatic logic sub_hit(input logic [4:0] a,
                                   input logic [4:0] reg_no,
                                   input logic strobe);
    sub_hit = strobe && (a == reg_no);
  endfunction : sub_hit

  // Host task-file decode
  function automatic logic host_hit(input logic [3:0] a,
                                    input logic [3:0] reg_no,
                                    input logic strobe);
    host_hit = strobe && (a == reg_no);
  endfunction : host_hit

  // ----------
  // Host mode decode
  // ----------
  // Decoded from the written code so the mode outputs are flops
  wire [2:0] hsel_d = sub_wdata[2:0];
  wire atapi_d = (hsel_d == ATR_HSEL_ATAPI);
  // Unknown and reserved codes leave the host bus floating
  wire pins_off_d = !(atapi_d || hsel_d == ATR_HSEL_LEGACY_A ||
                      hsel_d == ATR_HSEL_LEGACY_B);
  wire is_atapi = atapi_q;

  // ----------
  // Strobe decode
  // ----------
  wire w_buffer_memory_config = sub_hit(sub_addr, ATR_W_BUFFER_MEMORY_CONFIG, sub_wr);
  wire w_status = sub_hit(sub_addr, ATR_W_STATUS, sub_wr) && is_atapi;
  wire w_trigger = sub_hit(sub_addr, ATR_W_TRIGGER, sub_wr);
  wire w_drvaddr = sub_hit(sub_addr, ATR_W_DRVADDR, sub_wr);
  wire w_sector = sub_hit(sub_addr, ATR_W_SECTOR, sub_wr);
  wire w_xfer = sub_hit(sub_addr, ATR_W_XFER, sub_wr);
  wire w_drvhead = sub_hit(sub_addr, ATR_W_DRVHEAD, sub_wr);
  wire w_reason = sub_hit(sub_addr, ATR_W_REASON, sub_wr);
  wire w_error = sub_hit(sub_addr, ATR_W_ERROR, sub_wr);
  wire w_reset = sub_hit(sub_addr, ATR_W_RESET, sub_wr);
  wire r_command = sub_hit(sub_addr, ATR_R_COMMAND, sub_rd);
  wire r_devctl = sub_hit(sub_addr, ATR_R_DEVCTL, sub_rd);

  wire hw_errfeat = host_hit(host_addr, ATR_H_ERRFEAT, host_wr);
  wire hw_reason = host_hit(host_addr, ATR_H_REASON, host_wr);
  wire hw_sector = host_hit(host_addr, ATR_H_SECTOR, host_wr);
  wire hw_drvhead = host_hit(host_addr, ATR_H_DRVHEAD, host_wr);
  wire hw_command = host_hit(host_addr, ATR_H_STATCMD, host_wr) && is_atapi;
  wire hw_devctl = host_hit(host_addr, ATR_H_DEVCTL, host_wr);
  wire hr_status = host_hit(host_addr, ATR_H_STATCMD, host_rd) && is_atapi;

  // ----------
  // Drive selection and host events
  // ----------
  // Selected when the host's drive bit matches our drive number
  wire selected = (drvhead_q[ATR_DRV_BIT] == xfer_q[ATR_REAL_DRIVE_NUMBER_BIT]);
  wire is_diag = (host_wdata == ATR_CMD_DIAG);
  // Diagnostic reaches every drive, other commands only the selected one
  wire cmd_event = hw_command && (selected || is_diag);
  wire srst_event = hw_devctl && host_wdata[ATR_SRST_BIT] && is_atapi;
  wire bsy_event = cmd_event || srst_event;
  // Trigger only works in packet mode and for the selected drive
  wire trig_event = w_trigger && is_atapi && selected;
  wire host_irq_clr = hr_status || hw_command;

  // ----------
  // Next values of the interrupt levels; set beats clear
  // ----------
  wire host_irq_d = trig_event || (host_irq_q && !host_irq_clr);
  wire cmd_irq_d = cmd_event || (cmd_irq_q && !r_command);
  wire srst_irq_d = srst_event || (srst_irq_q && !r_devctl);

  // Busy bit: host events win over a sub-CPU status write
  wire [7:0] status_w = w_status ? sub_wdata : status_q;
  wire [7:0] status_d = {status_w[7] || bsy_event, status_w[6:0]};

  // ----------
  // Memory configuration decode
  // ----------
  wire [1:0] prio = buffer_memory_config_q[ATR_PRIO_HI:ATR_PRIO_LO];
  // Field value n allows n+1 successive top-priority host accesses
  wire [2:0] burst = {1'b0, prio} + 3'h1;
  wire is_dram = !buffer_memory_config_q[ATR_STATIC_BIT];
  wire [8:0] rfr_top = buffer_memory_config_q[ATR_REFRESH_DIVISOR_SEL_BIT] ?
                       ATR_RFR_TOP_SLOW : ATR_RFR_TOP_FAST;
  wire rfr_wrap = (rfr_cnt_q >= rfr_top);
  wire [8:0] rfr_cnt_d = (rfr_wrap || !is_dram) ? 9'h000 :
                         rfr_cnt_q + 9'h001;
  // SRAM needs no refresh, so requests are held off
  wire refresh_d = rfr_wrap && is_dram;

  atr_mem_cfg_t mem_cfg_d;
  assign mem_cfg_d.host_burst = burst;
  assign mem_cfg_d.nibble_wide = buffer_memory_config_q[ATR_WIDTH_BIT];
  assign mem_cfg_d.sram_sel = buffer_memory_config_q[ATR_STATIC_BIT];
  assign mem_cfg_d.no_cache = buffer_memory_config_q[ATR_CACHE_BIT];

  // ----------
  // Transfer control decode
  // ----------
  wire [2:0] ttype = xfer_q[2:0];
  wire to_host_pkt = (ttype == ATR_TT_HOST_TO_SUB);
  wire from_sub_pkt = (ttype == ATR_TT_SUB_TO_HOST);
  wire bulk = (ttype[2:1] == 2'b00);
  // Legacy modes rely on software keeping to the four path types
  wire [15:0] max_d = bulk ? (is_atapi ? ATR_MAX_ATAPI : ATR_MAX_LEGACY) :
                      (to_host_pkt || from_sub_pkt) ? ATR_MAX_PACKET :
                      16'h0000;

  atr_xfer_cfg_t xfer_cfg_d;
  assign xfer_cfg_d.transfer_type = ttype;
  // Host-to-sub packet moves are PIO whatever the DMA bit says
  assign xfer_cfg_d.use_dma_sel =
    xfer_q[ATR_USE_DMA_SEL_BIT] && !to_host_pkt;
  assign xfer_cfg_d.multiword_sel = xfer_q[ATR_MULTI_BIT];
  assign xfer_cfg_d.subcode_irq_enable = xfer_q[ATR_SUBCODE_IRQ_ENABLE_BIT];
  assign xfer_cfg_d.use_byte_counter = !to_host_pkt;
  assign xfer_cfg_d.max_bytes = max_d;

  // ----------
  // Read data selection
  // ----------
  // Write-only registers are not on the sub-CPU read side
  wire [7:0] sub_rdata_d =
    (sub_addr == ATR_R_COMMAND) ? command_q :
    (sub_addr == ATR_R_SECTOR) ? sector_q :
    (sub_addr == ATR_R_DEVCTL) ? devctl_q :
    (sub_addr == ATR_R_DRVHEAD) ? (drvhead_q | ATR_DRVHEAD_ONES) :
    (sub_addr == ATR_R_REASON) ? reason_q :
    (sub_addr == ATR_R_FEATURES) ? features_q :
    (sub_addr == ATR_R_BUFFER_MEMORY_CONFIG) ? buffer_memory_config_q :
    (sub_addr == ATR_R_XFER) ? {1'b0, xfer_q[6:0]} :
    8'h00;

  wire [7:0] host_rdata_d =
    (host_addr == ATR_H_ERRFEAT) ? error_q :
    (host_addr == ATR_H_REASON) ? reason_q :
    (host_addr == ATR_H_SECTOR) ? sector_q :
    (host_addr == ATR_H_DRVHEAD) ? (drvhead_q | ATR_DRVHEAD_ONES) :
    (host_addr == ATR_H_STATCMD) ? status_q :
    (host_addr == ATR_H_DRVADDR) ? drvaddr_q :
    8'h00;

  // ----------
  // Host mode register; survives the soft reset it is written by
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hsel_q <= ATR_HSEL_RST;
      atapi_q <= 1'b0;
      pins_off_q <= 1'b1;
    end else if (w_reset) begin
      hsel_q <= hsel_d;
      atapi_q <= atapi_d;
      pins_off_q <= pins_off_d;
    end
  end

  // ----------
  // Configuration and transfer control
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buffer_memory_config_q <= ATR_BUFFER_MEMORY_CONFIG_RST;
      xfer_q <= ATR_XFER_RST;
    end else if (w_reset) begin
      buffer_memory_config_q <= ATR_BUFFER_MEMORY_CONFIG_RST;
      xfer_q <= ATR_XFER_RST;
    end else begin
      if (w_buffer_memory_config) buffer_memory_config_q <= sub_wdata;
      if (w_xfer) xfer_q <= {1'b0, sub_wdata[6:0]};
    end
  end

  // ----------
  // Status register and busy
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= ATR_STATUS_RST;
    end else if (w_reset) begin
      status_q <= ATR_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------
  // Task file written by the host
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      command_q <= 8'h00;
      devctl_q <= 8'h00;
      features_q <= 8'h00;
    end else if (w_reset) begin
      command_q <= 8'h00;
      devctl_q <= 8'h00;
      features_q <= 8'h00;
    end else begin
      if (hw_command) command_q <= host_wdata;
      if (hw_devctl) devctl_q <= host_wdata;
      if (hw_errfeat) features_q <= host_wdata;
    end
  end

  // ----------
  // Task file shared by both sides; host write wins a collision
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sector_q <= 8'h00;
      drvhead_q <= ATR_DRVHEAD_ONES;
      reason_q <= 8'h00;
    end else if (w_reset) begin
      sector_q <= 8'h00;
      drvhead_q <= ATR_DRVHEAD_ONES;
      reason_q <= 8'h00;
    end else begin
      if (hw_sector) sector_q <= host_wdata;
      else if (w_sector) sector_q <= sub_wdata;
      if (hw_drvhead) drvhead_q <= host_wdata | ATR_DRVHEAD_ONES;
      else if (w_drvhead) drvhead_q <= sub_wdata | ATR_DRVHEAD_ONES;
      if (hw_reason) reason_q <= host_wdata;
      else if (w_reason) reason_q <= sub_wdata;
    end
  end

  // ----------
  // Task file written by the sub-CPU only
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drvaddr_q <= 8'h00;
      error_q <= 8'h00;
    end else if (w_reset) begin
      drvaddr_q <= 8'h00;
      error_q <= 8'h00;
    end else begin
      if (w_drvaddr) drvaddr_q <= sub_wdata;
      if (w_error) error_q <= sub_wdata;
    end
  end

  // ----------
  // Interrupt levels
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_irq_q <= 1'b0;
      cmd_irq_q <= 1'b0;
      srst_irq_q <= 1'b0;
    end else if (w_reset) begin
      host_irq_q <= 1'b0;
      cmd_irq_q <= 1'b0;
      srst_irq_q <= 1'b0;
    end else begin
      host_irq_q <= host_irq_d;
      cmd_irq_q <= cmd_irq_d;
      srst_irq_q <= srst_irq_d;
    end
  end

  // ----------
  // Refresh divider
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rfr_cnt_q <= 9'h000;
      refresh_q <= 1'b0;
    end else begin
      rfr_cnt_q <= rfr_cnt_d;
      refresh_q <= refresh_d;
    end
  end

  // ----------
  // Output staging; read data and decoded setup come from flops
  // ----------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sub_rdata_q <= 8'h00;
      host_rdata_q <= 8'h00;
      mem_cfg_q <= '0;
      xfer_cfg_q <= '0;
    end else begin
      sub_rdata_q <= sub_rdata_d;
      host_rdata_q <= host_rdata_d;
      mem_cfg_q <= mem_cfg_d;
      xfer_cfg_q <= xfer_cfg_d;
    end
  end

  // ----------
  // Output drive
  // ----------
  assign sub_rdata = sub_rdata_q;
  assign host_rdata = host_rdata_q;
  assign host_irq = host_irq_q;
  assign command_received_irq = cmd_irq_q;
  assign soft_reset_irq = srst_irq_q;
  assign host_mode = hsel_q;
  assign host_pins_tristate = pins_off_q;
  assign atapi_mode = atapi_q;
  assign mem_cfg = mem_cfg_q;
  assign refresh_req = refresh_q;
  assign xfer_cfg = xfer_cfg_q;
  assign busy = status_q[ATR_BSY_BIT];

endmodule : atr_regs

// ---- verif/atr_regs_asserts.sv ----
// Port checker for the task-file and buffer setup register bank.
// Assumes the bind at the foot; one clock, async active-high reset.
`timescale 1ns/1ps
module atr_regs_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request ports
  input wire logic [4:0] sub_addr,
  input wire logic sub_wr,
  input wire logic sub_rd,
  input wire logic [7:0] sub_wdata,
  input wire logic [3:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  // Outputs under watch
  input wire logic host_irq,
  input wire logic command_received_irq,
  input wire logic soft_reset_irq,
  input wire logic atapi_mode,
  input wire atr_pkg::atr_mem_cfg_t mem_cfg,
  input wire atr_pkg::atr_xfer_cfg_t xfer_cfg,
  input wire logic busy
);
  import atr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Write data two edges back; config ports trail the register a cycle
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;
  always_ff @(posedge mclk) begin
    wd1_q <= sub_wdata;
    wd2_q <= wd1_q;
  end
  // Decoded strobes
  wire trg = sub_wr && sub_addr == ATR_W_TRIGGER;
  wire h_cmd = host_wr && host_addr == ATR_H_STATCMD;
  wire h_dev = host_wr && host_addr == ATR_H_DEVCTL;
  sequence s_buffer_memory_config_wr; sub_wr && sub_addr == ATR_W_BUFFER_MEMORY_CONFIG ##2 1'b1; endsequence
  sequence s_xfer_wr; sub_wr && sub_addr == ATR_W_XFER ##2 1'b1; endsequence
  property p_legacy; !atapi_mode && !host_irq && trg |=> !host_irq; endproperty
  property p_stat_rd;
    atapi_mode && host_rd && host_addr == ATR_H_STATCMD && !trg |=> !host_irq;
  endproperty
  property p_diag;
    atapi_mode && h_cmd && host_wdata == ATR_CMD_DIAG |=>
      command_received_irq && busy;
  endproperty
  property p_srst;
    atapi_mode && h_dev && host_wdata[2] |=> soft_reset_irq && busy;
  endproperty
  property p_cmd_clr;
    sub_rd && sub_addr == ATR_R_COMMAND && !h_cmd |=> !command_received_irq;
  endproperty
  property p_dev_clr;
    sub_rd && sub_addr == ATR_R_DEVCTL && !h_dev |=> !soft_reset_irq;
  endproperty
  property p_buffer_memory_config;
    s_buffer_memory_config_wr |-> mem_cfg == {3'(wd2_q[6:5]) + 3'h1, wd2_q[2:0]};
  endproperty
  property p_xfer;
    s_xfer_wr |-> xfer_cfg.transfer_type == wd2_q[2:0] &&
      xfer_cfg.multiword_sel == wd2_q[6] &&
      xfer_cfg.use_dma_sel == (wd2_q[5] && wd2_q[2:0] != 3'h4) &&
      xfer_cfg.subcode_irq_enable == wd2_q[4];
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy trigger");
  a_stat_rd: assert property (p_stat_rd) else $error("irq kept");
  a_diag: assert property (p_diag) else $error("diag missed");
  a_srst: assert property (p_srst) else $error("srst missed");
  a_cmd_clr: assert property (p_cmd_clr) else $error("cmd irq kept");
  a_dev_clr: assert property (p_dev_clr) else $error("srst irq kept");
  a_buffer_memory_config: assert property (p_buffer_memory_config) else $error("mem cfg");
  a_xfer: assert property (p_xfer) else $error("xfer cfg");
endmodule : atr_regs_asserts
bind atr_regs atr_regs_asserts i_chk (.mclk(mclk), .rst(rst),
  .sub_addr(sub_addr), .sub_wr(sub_wr), .sub_rd(sub_rd),
  .sub_wdata(sub_wdata), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_wdata(host_wdata), .host_irq(host_irq),
  .command_received_irq(command_received_irq),
  .soft_reset_irq(soft_reset_irq), .mem_cfg(mem_cfg),
  .xfer_cfg(xfer_cfg), .busy(busy), .atapi_mode(atapi_mode));

// ---- verif/atr_host_model.sv ----
// Behavioural packet host driving the task-file strobes of the bank.
// Assumes the bench calls its tasks; pins move on falling edges only.
`timescale 1ns/1ps
module atr_host_model (
  // Clock
  input wire logic mclk,
  // Task-file port
  output logic [3:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  // Idle bus; released data is inverted so stale values never match
  initial begin
    host_addr = 4'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // One-cycle write strobe
  task automatic hw(input logic [3:0] a, input logic [7:0] v);
    @(negedge mclk);
    host_addr = a;
    host_wdata = v;
    host_wr = 1'b1;
    @(negedge mclk);
    host_wr = 1'b0;
    host_wdata = ~v;
  endtask : hw
  // One-cycle read strobe; registered data settles by the next fall
  task automatic hr(input logic [3:0] a, output logic [7:0] v);
    @(negedge mclk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge mclk);
    host_rd = 1'b0;
    v = host_rdata;
  endtask : hr
endmodule : atr_host_model

// ---- verif/atr_regs_test.sv ----
// Self-checking bench for the register bank, host side by the model.
// Assumes the checker binds itself; inputs move on falling edges.
`timescale 1ns/1ps
module atr_regs_test;
  import atr_pkg::*;
  // Design-side signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] sub_addr = 5'h00;
  logic sub_wr = 1'b0;
  logic sub_rd = 1'b0;
  logic [7:0] sub_wdata = 8'h00;
  logic [7:0] sub_rdata, host_wdata, host_rdata, d;
  logic [3:0] host_addr;
  logic host_wr, host_rd, host_irq, command_received_irq, soft_reset_irq;
  logic [2:0] host_mode;
  logic host_pins_tristate, atapi_mode, refresh_req, busy;
  atr_mem_cfg_t mem_cfg;
  atr_xfer_cfg_t xfer_cfg;
  int err_count = 0;
  int num_checks = 0;
  int n;
  always #10 mclk = ~mclk;
  atr_regs i_dut (.*);
  atr_host_model i_host (.*);
  // Shared helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic sw(input logic [4:0] a, input logic [7:0] v);
    @(negedge mclk);
    sub_addr = a;
    sub_wdata = v;
    sub_wr = 1'b1;
    @(negedge mclk);
    sub_wr = 1'b0;
  endtask : sw
  task automatic sr(input logic [4:0] a, output logic [7:0] v);
    @(negedge mclk);
    sub_addr = a;
    sub_rd = 1'b1;
    @(negedge mclk);
    sub_rd = 1'b0;
    v = sub_rdata;
  endtask : sr
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // Reset values, unmapped read, host-select codes 0 to 3
  task automatic t_reset_mode;
    chk({busy, host_mode, host_pins_tristate, atapi_mode}, 6'h3e);
    sr(ATR_R_XFER, d);
    chk(d, 8'h08);
    sr(5'h00, d);
    chk(d, 8'h00);
    for (int m = 2; m < 6; m++) begin
      sw(ATR_W_RESET, 8'(m % 4));
      chk({host_mode, atapi_mode, host_pins_tristate},
          {3'(m % 4), m % 4 == 1, m % 4 == 3});
    end
    sr(ATR_R_DRVHEAD, d);
    chk(d, 8'he0);
    i_host.hr(ATR_H_STATCMD, d);
    chk(d, 8'h80);
    $display("reset and mode test done");
  endtask : t_reset_mode
  // Priority, width, type, cache fields, then refresh spacing
  task automatic t_buffer_memory_config;
    for (int p = 0; p < 4; p++) begin
      sw(ATR_W_BUFFER_MEMORY_CONFIG, {1'b0, 2'(p), 2'b00, 3'(p + 3)});
      @(negedge mclk);
      chk(mem_cfg, {3'(p + 1), 3'(p + 3)});
    end
    sr(ATR_R_BUFFER_MEMORY_CONFIG, d);
    chk(d, 8'h66);
    // The first pulse may follow the old rate, so time the second gap
    for (int i = 0; i < 3; i++) begin
      sw(ATR_W_BUFFER_MEMORY_CONFIG, i == 0 ? 8'h08 : i == 1 ? 8'h00 : 8'h02);
      repeat (2) begin
        n = 0;
        do begin
          @(negedge mclk);
          n++;
        end while (refresh_req !== 1'b1 && n < 450);
      end
      chk(16'(n), i == 0 ? 16'h0190 : i == 1 ? 16'h00c8 : 16'h01c2);
      if (n == 450 && i < 2) final_report;
    end
    $display("memory config test done");
  endtask : t_buffer_memory_config
  // Command register, drive select, diagnostic, busy
  task automatic t_cmd;
    sw(ATR_W_STATUS, 8'h00);
    chk(busy, 1'b0);
    i_host.hw(ATR_H_STATCMD, 8'ha1);
    chk({command_received_irq, busy}, 2'b00);
    i_host.hw(ATR_H_STATCMD, 8'h90);
    chk({command_received_irq, busy}, 2'b11);
    sr(ATR_R_COMMAND, d);
    chk({d, command_received_irq}, 9'h120);
    i_host.hw(ATR_H_DRVHEAD, 8'h10);
    sr(ATR_R_DRVHEAD, d);
    chk(d, 8'hf0);
    sw(ATR_W_STATUS, 8'h00);
    i_host.hw(ATR_H_STATCMD, 8'ha0);
    chk({command_received_irq, busy}, 2'b11);
    sr(ATR_R_COMMAND, d);
    chk({d, command_received_irq}, 9'h140);
    $display("command test done");
  endtask : t_cmd
  // Host interrupt raised, held, cleared; ignored in a legacy mode
  task automatic t_hirq;
    sw(ATR_W_STATUS, 8'h51);
    sw(ATR_W_TRIGGER, 8'h00);
    repeat (3) @(negedge mclk);
    chk(host_irq, 1'b1);
    i_host.hr(ATR_H_STATCMD, d);
    chk({d, host_irq}, 9'h0a2);
    sw(ATR_W_TRIGGER, 8'h00);
    i_host.hw(ATR_H_STATCMD, 8'h00);
    chk(host_irq, 1'b0);
    sr(ATR_R_COMMAND, d);
    sw(ATR_W_RESET, 8'h02);
    sw(ATR_W_DRVHEAD, 8'h10);
    sw(ATR_W_TRIGGER, 8'h00);
    chk(host_irq, 1'b0);
    sw(ATR_W_RESET, 8'h01);
    $display("host irq test done");
  endtask : t_hirq
  // Soft reset request and task-file mirrors in both directions
  task automatic t_mirror;
    i_host.hw(ATR_H_DEVCTL, 8'h04);
    chk({soft_reset_irq, busy}, 2'b11);
    sr(ATR_R_DEVCTL, d);
    chk({d, soft_reset_irq}, 9'h008);
    i_host.hw(ATR_H_SECTOR, 8'h5a);
    sr(ATR_R_SECTOR, d);
    chk(d, 8'h5a);
    sw(ATR_W_DRVADDR, 8'hc3);
    i_host.hr(ATR_H_DRVADDR, d);
    chk(d, 8'hc3);
    sw(ATR_W_ERROR, 8'h96);
    i_host.hr(ATR_H_ERRFEAT, d);
    chk(d, 8'h96);
    i_host.hw(ATR_H_ERRFEAT, 8'h3c);
    sr(ATR_R_FEATURES, d);
    chk(d, 8'h3c);
    sw(ATR_W_REASON, 8'h02);
    i_host.hr(ATR_H_REASON, d);
    chk(d, 8'h02);
    $display("mirror test done");
  endtask : t_mirror
  // Every transfer type; legacy mode keeps to type 0 only
  task automatic t_xfer;
    for (int t = 0; t < 8; t++) begin
      sw(ATR_W_XFER, 8'hf8 | 8'(t));
      @(negedge mclk);
      if (t == 4) chk(xfer_cfg.use_byte_counter, 1'b0);
      if (t < 2 || t > 3)
        chk(xfer_cfg.max_bytes,
            t < 2 ? 16'hffff : t < 6 ? 16'h000c : 16'h0000);
      sr(ATR_R_XFER, d);
      chk(d, 8'h78 | 8'(t));
    end
    sw(ATR_W_RESET, 8'h00);
    @(negedge mclk);
    chk(xfer_cfg.max_bytes, 16'h7fff);
    $display("transfer test done");
  endtask : t_xfer
  // Main sequence
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    t_reset_mode;
    t_buffer_memory_config;
    t_cmd;
    t_hirq;
    t_mirror;
    t_xfer;
    final_report;
  end
endmodule : atr_regs_test
